// ==== hdl/wdr_params.svh ====
// Purpose: constants for the watchdog and reset supervisor
// Assumes: 125 MHz clock from the always-on oscillator
// Notes:   times in ns; cycle counts derived below
`ifndef WDR_PARAMS_SVH
`define WDR_PARAMS_SVH

// ==========================================================
// clock and time base
`define WDR_CLK_PERIOD_NS 8
`define WDR_TICK_NS 1000000
`define WDR_TICK_CYCLES ((`WDR_TICK_NS) / (`WDR_CLK_PERIOD_NS))

// ==========================================================
// reset pin timing (least times, rounded up)
`define WDR_FILTER_NS 1000
`define WDR_FILTER_CYCLES (((`WDR_FILTER_NS) + (`WDR_CLK_PERIOD_NS) - 1) / (`WDR_CLK_PERIOD_NS))
`define WDR_SHORT_NS 1000000
`define WDR_SHORT_CYCLES (((`WDR_SHORT_NS) + (`WDR_CLK_PERIOD_NS) - 1) / (`WDR_CLK_PERIOD_NS))
`define WDR_LONG_NS 20000000
`define WDR_LONG_CYCLES (((`WDR_LONG_NS) + (`WDR_CLK_PERIOD_NS) - 1) / (`WDR_CLK_PERIOD_NS))

// ==========================================================
// period field
`define WDR_PERIOD_W 3
`define WDR_PERIOD_DEFAULT 3'h4
`define WDR_PERIOD_BASE_MS 11'h008
`define WDR_MS_W 11

`endif

// ==== hdl/wdr_pkg.sv ====
// Purpose: types for the watchdog and reset supervisor
// Assumes: nothing
// Notes:   encodings follow the chip mode code field
package wdr_pkg;

    // ==========================================================
    // chip mode code
    typedef enum logic [1:0]
    {
        MC_STANDBY = 2'h0,
        MC_SLEEP   = 2'h1,
        MC_NORM_A  = 2'h2,
        MC_NORM_B  = 2'h3
    } chip_mode_code_t;

    // ==========================================================
    // watchdog mode
    typedef enum logic [1:0]
    {
        WD_OFF     = 2'b00,
        WD_WINDOW  = 2'b01,
        WD_TIMEOUT = 2'b10
    } wd_mode_t;

    // ==========================================================
    // reset pulse sequencer
    typedef enum logic [1:0]
    {
        RS_IDLE   = 2'b00,
        RS_DRIVE  = 2'b01,
        RS_SETTLE = 2'b10
    } rst_state_t;

    // ==========================================================
    // conditions checked on a sleep request
    typedef struct packed
    {
        logic       irq_out_n;
        logic       wake_pending;
        logic       can_standby_ctrl;
        logic [1:0] wake1_irq_ctrl;
        logic [1:0] wake2_irq_ctrl;
    } sleep_check_t;

endpackage

// ==== hdl/watchdog_reset_failsafe_ctrl.sv ====
// Purpose: watchdog, system reset sources, reset pin, enable and limp outputs
// Assumes: CLK_IN is the always-on oscillator clock; inputs synchronous
// Notes:   Off mode = RESETN_IN low
`timescale 1ns/1ns
`default_nettype none
`include "wdr_params.svh"

module watchdog_reset_failsafe_ctrl
#(
    parameter int TICK_CYCLES  = `WDR_TICK_CYCLES,
    parameter int FILT_CYCLES  = `WDR_FILTER_CYCLES,
    parameter int SHORT_CYCLES = `WDR_SHORT_CYCLES,
    parameter int LONG_CYCLES  = `WDR_LONG_CYCLES
)
(
    input  wire logic                     CLK_IN,
    input  wire logic                     RESETN_IN,
    input  wire logic [1:0]               CHIP_MODE_CODE_IN,
    input  wire logic                     OVERTEMP_IN,
    input  wire logic                     V1_UNDERVOLT_IN,
    input  wire logic                     WD_DISABLE_PIN_IN,
    input  wire logic                     WD_WRITE_IN,
    input  wire logic [`WDR_PERIOD_W-1:0] WD_PERIOD_SEL_IN,
    input  wire logic                     WD_MODE_CTRL_IN,
    input  wire logic                     IRQ_PENDING_IN,
    input  wire logic                     CYCLIC_IRQ_CLR_IN,
    input  wire logic                     SOFT_RESET_BIT_IN,
    input  wire logic                     SLEEP_REQ_IN,
    input  wire wdr_pkg::sleep_check_t    SLEEP_CHECK_IN,
    input  wire logic                     ENABLE_CTRL_WR_IN,
    input  wire logic                     ENABLE_OUT_CTRL_IN,
    input  wire logic                     FALLBACK_WARN_CLR_IN,
    input  wire logic                     FALLBACK_CTRL_CLR_IN,
    input  wire logic                     LONG_PULSE_STRAP_IN,
    input  wire logic                     SYS_RESET_N_PIN_IN,
    output logic                          SYS_RESET_N_PIN_OUT,
    output logic                          SYS_RESET_N_PIN_OE_OUT,
    output logic [`WDR_PERIOD_W-1:0]      WD_PERIOD_SEL_OUT,
    output logic                          WD_MODE_CTRL_OUT,
    output wdr_pkg::wd_mode_t             WD_MODE_OUT,
    output logic                          CYCLIC_IRQ_FLAG_OUT,
    output logic                          ENABLE_OUT,
    output logic                          FALLBACK_WARN_OUT,
    output logic                          FALLBACK_CTRL_OUT,
    output logic                          LIMP_N_OUT,
    output logic                          LIMP_OE_OUT
);

    // ==========================================================
    // elaboration checks
    generate
        if (TICK_CYCLES < 2 || FILT_CYCLES < 1 || SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
        begin : g_bad
            $error("watchdog_reset_failsafe_ctrl: bad timing parameters");
        end
    endgenerate

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int FW = $clog2(FILT_CYCLES + 1);
    localparam int PW = $clog2(LONG_CYCLES + 1);

    // period code to milliseconds; code 100 gives 128
    function automatic logic [`WDR_MS_W-1:0] period_ms(input logic [`WDR_PERIOD_W-1:0] code);
        period_ms = `WDR_PERIOD_BASE_MS << code;
    endfunction

    // ==========================================================
    // declarations
    logic [TW-1:0]             tick_cnt_q;
    logic                      tick;
    logic [`WDR_MS_W-1:0]      elapsed_q;
    logic [`WDR_MS_W-1:0]      per_ms;
    logic [`WDR_PERIOD_W-1:0]  period_q;
    logic                      wmc_q;
    logic                      ci_q;
    logic                      dis_q;
    logic                      dis_valid_q;
    logic                      uv_q;
    logic                      ot_q;
    logic                      por_q;
    logic                      enc_q;
    logic                      fallback_warn_bit_q;
    logic                      lhc_q;
    logic [FW-1:0]             filt_q;
    logic [PW-1:0]             pulse_q;
    wdr_pkg::rst_state_t       rst_state_q;
    wdr_pkg::wd_mode_t         mode_d;
    wdr_pkg::wd_mode_t         mode_q;
    logic                      normal;
    logic                      standby;
    logic                      irq_any;
    logic                      wmc_change;
    logic                      wmc_accept;
    logic                      ovf;
    logic                      wd_rst;
    logic                      long_cause;
    logic                      ext_rst;
    logic                      sleep_rst;
    logic                      any_rst;
    logic                      ci_set;
    logic                      ot_force;

    assign normal  = CHIP_MODE_CODE_IN[1] && !OVERTEMP_IN;
    assign standby = (CHIP_MODE_CODE_IN == wdr_pkg::MC_STANDBY) && !OVERTEMP_IN;
    assign irq_any = IRQ_PENDING_IN || ci_q;
    assign ot_force = OVERTEMP_IN;

    // ==========================================================
    // mode selection
    always_comb
    begin
        mode_d = wdr_pkg::WD_OFF;
        if (!WD_DISABLE_PIN_IN && !OVERTEMP_IN)
        begin
            if (normal)
                mode_d = wmc_q ? wdr_pkg::WD_TIMEOUT : wdr_pkg::WD_WINDOW;
            else if (standby && !wmc_q)
                mode_d = wdr_pkg::WD_TIMEOUT;
        end
    end

    // ==========================================================
    // ms tick; oscillator never stops
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            tick_cnt_q <= '0;
        else if (tick)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + TW'(1);
    end
    assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

    // ==========================================================
    // watchdog events
    assign per_ms     = period_ms(period_q);
    assign wmc_change = WD_WRITE_IN && (WD_MODE_CTRL_IN != wmc_q);
    assign wmc_accept = !(standby && irq_any);
    assign ovf        = (mode_d != wdr_pkg::WD_OFF) && tick && (elapsed_q + `WDR_MS_W'(1) >= per_ms);
    assign ci_set     = (mode_d == wdr_pkg::WD_TIMEOUT) && ovf && !ci_q;

    always_comb
    begin
        wd_rst = 1'b0;
        if (mode_d == wdr_pkg::WD_WINDOW && WD_WRITE_IN && elapsed_q < (per_ms >> 1))
            wd_rst = 1'b1;
        if (mode_d == wdr_pkg::WD_WINDOW && ovf && !WD_WRITE_IN)
            wd_rst = 1'b1;
        if (mode_d == wdr_pkg::WD_TIMEOUT && ovf && ci_q && !WD_WRITE_IN)
            wd_rst = 1'b1;
        if (dis_valid_q && (dis_q != WD_DISABLE_PIN_IN) && (normal || standby))
            wd_rst = 1'b1;
        if (normal && wmc_change)
            wd_rst = 1'b1;
    end

    // ==========================================================
    // other reset sources
    assign sleep_rst = SLEEP_REQ_IN && (CHIP_MODE_CODE_IN == wdr_pkg::MC_SLEEP)
                     && (!SLEEP_CHECK_IN.irq_out_n || SLEEP_CHECK_IN.wake_pending
                     || (!SLEEP_CHECK_IN.can_standby_ctrl && SLEEP_CHECK_IN.wake1_irq_ctrl == 2'h0
                     && SLEEP_CHECK_IN.wake2_irq_ctrl == 2'h0));
    assign long_cause = (V1_UNDERVOLT_IN && !uv_q) || (ot_q && !OVERTEMP_IN) || por_q;
    assign ext_rst    = (filt_q == FW'(FILT_CYCLES));
    assign any_rst    = (rst_state_q == wdr_pkg::RS_IDLE)
                      && (wd_rst || sleep_rst || long_cause || ext_rst || SOFT_RESET_BIT_IN);

    // ==========================================================
    // watchdog timer
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            elapsed_q <= '0;
        else if (mode_d == wdr_pkg::WD_OFF || rst_state_q != wdr_pkg::RS_IDLE)
            elapsed_q <= '0;
        else if (WD_WRITE_IN)
            elapsed_q <= '0;
        else if (ci_set)
            elapsed_q <= '0;
        else if (tick)
            elapsed_q <= elapsed_q + `WDR_MS_W'(1);
    end

    // ==========================================================
    // period field and mode-control bit
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            period_q <= `WDR_PERIOD_DEFAULT;
        else if (wd_rst && rst_state_q == wdr_pkg::RS_IDLE)
            period_q <= `WDR_PERIOD_DEFAULT;
        else if (WD_WRITE_IN)
            period_q <= WD_PERIOD_SEL_IN;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            wmc_q <= 1'b0;
        else if (wmc_change && wmc_accept)
            wmc_q <= WD_MODE_CTRL_IN;
        else if (standby && wmc_q && irq_any)
            wmc_q <= 1'b0;
    end

    // ==========================================================
    // cyclic flag; set beats clear
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            ci_q <= 1'b0;
        else if (ci_set)
            ci_q <= 1'b1;
        else if (CYCLIC_IRQ_CLR_IN)
            ci_q <= 1'b0;
    end

    // ==========================================================
    // edge history
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            dis_q       <= 1'b0;
            dis_valid_q <= 1'b0;
            uv_q        <= 1'b0;
            ot_q        <= 1'b0;
        end
        else
        begin
            dis_q       <= WD_DISABLE_PIN_IN;
            dis_valid_q <= 1'b1;
            uv_q        <= V1_UNDERVOLT_IN;
            ot_q        <= OVERTEMP_IN;
        end
    end

    // release of block reset = leaving Off
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            por_q <= 1'b1;
        else if (rst_state_q == wdr_pkg::RS_IDLE)
            por_q <= 1'b0;
    end

    // ==========================================================
    // external reset filter; blind while busy
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            filt_q <= '0;
        else if (rst_state_q != wdr_pkg::RS_IDLE || SYS_RESET_N_PIN_IN || ext_rst)
            filt_q <= '0;
        else
            filt_q <= filt_q + FW'(1);
    end

    // ==========================================================
    // reset pulse sequencer
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rst_state_q <= wdr_pkg::RS_IDLE;
            pulse_q     <= '0;
        end
        else
        begin
            case (rst_state_q)
                wdr_pkg::RS_IDLE:
                begin
                    if (any_rst && ext_rst)
                        rst_state_q <= wdr_pkg::RS_SETTLE;
                    else if (any_rst)
                    begin
                        rst_state_q <= wdr_pkg::RS_DRIVE;
                        pulse_q <= (long_cause && LONG_PULSE_STRAP_IN) ? PW'(LONG_CYCLES - 1)
                                                                       : PW'(SHORT_CYCLES - 1);
                    end
                end
                wdr_pkg::RS_DRIVE:
                begin
                    if (pulse_q == '0)
                        rst_state_q <= wdr_pkg::RS_SETTLE;
                    else
                        pulse_q <= pulse_q - PW'(1);
                end
                wdr_pkg::RS_SETTLE:
                begin
                    // slow pull-up or host may hold pin low
                    if (SYS_RESET_N_PIN_IN)
                        rst_state_q <= wdr_pkg::RS_IDLE;
                end
                default:
                    rst_state_q <= wdr_pkg::RS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // enable control bit
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            enc_q <= 1'b0;
        else if (any_rst)
            enc_q <= 1'b0;
        else if (ENABLE_CTRL_WR_IN)
            enc_q <= ENABLE_OUT_CTRL_IN;
    end

    // ==========================================================
    // limp warning and control; set beats clear
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            fallback_warn_bit_q <= 1'b0;
        else if (any_rst)
            fallback_warn_bit_q <= 1'b1;
        else if (FALLBACK_WARN_CLR_IN)
            fallback_warn_bit_q <= 1'b0;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            lhc_q <= 1'b0;
        else if ((any_rst && fallback_warn_bit_q) || ot_force)
            lhc_q <= 1'b1;
        else if (FALLBACK_CTRL_CLR_IN)
            lhc_q <= 1'b0;
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            mode_q                 <= wdr_pkg::WD_OFF;
            SYS_RESET_N_PIN_OUT    <= 1'b0;
            SYS_RESET_N_PIN_OE_OUT <= 1'b1;
            ENABLE_OUT             <= 1'b0;
            LIMP_N_OUT             <= 1'b1;
            LIMP_OE_OUT            <= 1'b0;
        end
        else
        begin
            mode_q                 <= mode_d;
            SYS_RESET_N_PIN_OUT    <= 1'b0;
            SYS_RESET_N_PIN_OE_OUT <= (rst_state_q == wdr_pkg::RS_DRIVE) && !(pulse_q == '0);
            ENABLE_OUT             <= enc_q && normal && !any_rst
                                      && (rst_state_q == wdr_pkg::RS_IDLE);
            LIMP_N_OUT             <= !lhc_q;
            LIMP_OE_OUT            <= lhc_q;
        end
    end

    assign WD_PERIOD_SEL_OUT   = period_q;
    assign WD_MODE_CTRL_OUT    = wmc_q;
    assign WD_MODE_OUT         = mode_q;
    assign CYCLIC_IRQ_FLAG_OUT = ci_q;
    assign FALLBACK_WARN_OUT   = fallback_warn_bit_q;
    assign FALLBACK_CTRL_OUT   = lhc_q;

endmodule

`default_nettype wire

// ==== tb/wdr_asserts.sv ====
// Purpose: port-level checks of the supervisor
// Assumes: bound to the top module
// Notes:   idle inferred from the reset line
`timescale 1ns/1ns
`default_nettype none
module wdr_asserts
#(
    parameter int LONG_CYCLES = 20
)
(
    input  wire logic              CLK_IN,
    input  wire logic              RESETN_IN,
    input  wire logic [1:0]        CHIP_MODE_CODE_IN,
    input  wire logic              OVERTEMP_IN,
    input  wire logic              WD_DISABLE_PIN_IN,
    input  wire logic              SOFT_RESET_BIT_IN,
    input  wire logic              SYS_RESET_N_PIN_IN,
    input  wire logic              SYS_RESET_N_PIN_OE_OUT,
    input  wire logic              WD_MODE_CTRL_OUT,
    input  wire wdr_pkg::wd_mode_t WD_MODE_OUT,
    input  wire logic              ENABLE_OUT,
    input  wire logic              FALLBACK_WARN_OUT,
    input  wire logic              FALLBACK_CTRL_OUT,
    input  wire logic              LIMP_N_OUT,
    input  wire logic              LIMP_OE_OUT
);
    logic [2:0]  quiet_q;
    logic [31:0] drive_q;

    // ==========================================================
    // helpers
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            quiet_q <= 3'h0;
        else if (SYS_RESET_N_PIN_OE_OUT || !SYS_RESET_N_PIN_IN)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            drive_q <= 32'h0;
        else
            drive_q <= SYS_RESET_N_PIN_OE_OUT ? drive_q + 32'h1 : 32'h0;
    end

    default clocking dc @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    // ==========================================================
    // properties
    chk_soft_drive:
        assert property (SOFT_RESET_BIT_IN && quiet_q > 3'h3 |-> ##2 SYS_RESET_N_PIN_OE_OUT)
        else $error("soft reset gave no pulse");
    chk_pin_change:
        assert property ($changed(WD_DISABLE_PIN_IN) && quiet_q > 3'h3 && CHIP_MODE_CODE_IN != 2'h1
            && !OVERTEMP_IN |-> ##2 SYS_RESET_N_PIN_OE_OUT)
        else $error("pin change gave no pulse");
    chk_enable_mode:
        assert property (ENABLE_OUT |-> $past(CHIP_MODE_CODE_IN[1]))
        else $error("enable high outside normal");
    chk_enable_drop:
        assert property (SYS_RESET_N_PIN_OE_OUT |-> !ENABLE_OUT)
        else $error("enable high during reset");
    chk_warn_set:
        assert property ($rose(SYS_RESET_N_PIN_OE_OUT) |-> FALLBACK_WARN_OUT)
        else $error("warn not set");
    chk_limp_follow:
        assert property ($rose(FALLBACK_CTRL_OUT) |=> !FALLBACK_CTRL_OUT || (LIMP_OE_OUT && !LIMP_N_OUT))
        else $error("limp output not active");
    chk_hot_limp:
        assert property (OVERTEMP_IN [*2] |-> FALLBACK_CTRL_OUT)
        else $error("limp control not forced");
    chk_pin_off:
        assert property (WD_DISABLE_PIN_IN [*3] |-> WD_MODE_OUT == wdr_pkg::WD_OFF)
        else $error("watchdog on with pin high");
    chk_window_sel:
        assert property ((!WD_DISABLE_PIN_IN && CHIP_MODE_CODE_IN[1] && !OVERTEMP_IN && !WD_MODE_CTRL_OUT) [*3]
            |-> WD_MODE_OUT == wdr_pkg::WD_WINDOW)
        else $error("window mode not selected");
    chk_pulse_max:
        assert property (drive_q <= LONG_CYCLES)
        else $error("reset pulse too long");
endmodule
`default_nettype wire

// ==== tb/mcu_reset_line.sv ====
// Purpose: microcontroller side of the reset line
// Assumes: pull-up on the line; device only pulls low
// Notes:   a request holds the line low
`timescale 1ns/1ns
`default_nettype none
module mcu_reset_line
#(
    parameter int HOLD_CYCLES = 6
)
(
    input  wire logic clk_in,
    input  wire logic sys_reset_n_pin_in,
    input  wire logic pull_req_in,
    input  wire logic dut_level_in,
    input  wire logic dut_oe_in,
    output logic      pin_out
);
    logic [7:0] hold_q;

    // ==========================================================
    // external reset hold
    always_ff @(posedge clk_in or negedge sys_reset_n_pin_in)
    begin
        if (!sys_reset_n_pin_in)
            hold_q <= 8'h0;
        else if (pull_req_in)
            hold_q <= 8'(HOLD_CYCLES);
        else if (hold_q != 8'h0)
            hold_q <= hold_q - 8'h1;
    end

    // pull-up unless someone pulls low
    assign pin_out = !((dut_oe_in && !dut_level_in) || hold_q != 8'h0);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: directed test of the watchdog and reset supervisor
// Assumes: short time constants
// Notes:   pulse lengths accepted within one cycle
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int TICK = 10;
    localparam int FILT = 3;
    localparam int SHORT = 8;
    localparam int LONG = 20;
    localparam int S_WR = 0, S_CI = 1, S_SWR = 2, S_SLP = 3, S_EN = 4, S_WCLR = 5, S_CCLR = 6;

    logic                  clk, sys_reset_n_pin, ot, uv, wd_off, wd_mode_ctrl, irq, en_val, strap, pull, pin, pin_d, pin_oe;
    logic [1:0]            mcode;
    logic [2:0]            psel, psel_o;
    logic [6:0]            strobe;
    wdr_pkg::sleep_check_t scheck;
    logic                  wmc_o, ci_o, en_o, warn_o, ctrl_o, limp_n, limp_oe;
    wdr_pkg::wd_mode_t     mode_o;
    int                    error_cnt = 0, tests_run = 0, cyc = 0, len;
    logic [6:0]            bad [3] = '{7'h10, 7'h70, 7'h40};

    watchdog_reset_failsafe_ctrl #(.TICK_CYCLES(TICK), .FILT_CYCLES(FILT), .SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut
    (
        .CLK_IN(clk), .RESETN_IN(sys_reset_n_pin), .CHIP_MODE_CODE_IN(mcode), .OVERTEMP_IN(ot), .V1_UNDERVOLT_IN(uv),
        .WD_DISABLE_PIN_IN(wd_off), .WD_WRITE_IN(strobe[S_WR]), .WD_PERIOD_SEL_IN(psel), .WD_MODE_CTRL_IN(wd_mode_ctrl),
        .IRQ_PENDING_IN(irq), .CYCLIC_IRQ_CLR_IN(strobe[S_CI]), .SOFT_RESET_BIT_IN(strobe[S_SWR]),
        .SLEEP_REQ_IN(strobe[S_SLP]), .SLEEP_CHECK_IN(scheck), .ENABLE_CTRL_WR_IN(strobe[S_EN]),
        .ENABLE_OUT_CTRL_IN(en_val), .FALLBACK_WARN_CLR_IN(strobe[S_WCLR]), .FALLBACK_CTRL_CLR_IN(strobe[S_CCLR]),
        .LONG_PULSE_STRAP_IN(strap), .SYS_RESET_N_PIN_IN(pin), .SYS_RESET_N_PIN_OUT(pin_d),
        .SYS_RESET_N_PIN_OE_OUT(pin_oe), .WD_PERIOD_SEL_OUT(psel_o), .WD_MODE_CTRL_OUT(wmc_o), .WD_MODE_OUT(mode_o),
        .CYCLIC_IRQ_FLAG_OUT(ci_o), .ENABLE_OUT(en_o), .FALLBACK_WARN_OUT(warn_o), .FALLBACK_CTRL_OUT(ctrl_o),
        .LIMP_N_OUT(limp_n), .LIMP_OE_OUT(limp_oe)
    );

    mcu_reset_line #(.HOLD_CYCLES(FILT + 3)) mcu
    (
        .clk_in(clk), .sys_reset_n_pin_in(sys_reset_n_pin), .pull_req_in(pull), .dut_level_in(pin_d), .dut_oe_in(pin_oe), .pin_out(pin)
    );

    // ==========================================================
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input int idx);
        @(posedge clk);
        strobe[idx] <= 1'b1;
        @(posedge clk);
        strobe[idx] <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [2:0] code, input logic w);
        @(posedge clk);
        psel <= code;
        wd_mode_ctrl <= w;
        pulse(S_WR);
    endtask

    // len: cycles driven low; 0 if none
    task automatic watch(input int n);
        len = 0;
        for (int i = 0; i < n && len == 0; i++)
        begin
            tick(1);
            while (pin_oe === 1'b1 && len < 4 * LONG)
            begin
                len++;
                tick(1);
            end
        end
        tick(4);
    endtask

    task automatic check_pulse(input int exp);
        check("pulse", 32'(len >= exp - 1 && len <= exp), 32'h1);
    endtask

    task automatic cm(input wdr_pkg::wd_mode_t exp);
        tick(3);
        check("mode", mode_o, exp);
    endtask

    // software clean-up after a reset
    task automatic clr_fb();
        pulse(S_WCLR);
        pulse(S_CCLR);
        pulse(S_CI);
        tick(2);
        check("warn", warn_o, 1'b0);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // sequence
    initial
    begin
        {sys_reset_n_pin, ot, uv, wd_off, wd_mode_ctrl, irq, en_val, pull, strobe} = '0;
        strap = 1'b1;
        mcode = 2'h0;
        psel = 3'h4;
        scheck = 7'h50;
        repeat (6) @(posedge clk);
        sys_reset_n_pin <= 1'b1;
        watch(60);
        check_pulse(LONG);
        check("period", psel_o, 3'h4);
        cm(wdr_pkg::WD_TIMEOUT);
        clr_fb();
        wr(3'h0, 1'b0);
        watch(90);
        check("len", len, 0);
        check("ci", ci_o, 1'b1);
        pulse(S_CI);
        check("ci", ci_o, 1'b0);
        tick(64);
        check("ci", ci_o, 1'b1);
        watch(120);
        check_pulse(SHORT);
        check("period", psel_o, 3'h4);
        clr_fb();
        wr(3'h0, 1'b0);
        @(posedge clk) mcode <= 2'h2;
        cm(wdr_pkg::WD_WINDOW);
        tick(44);
        wr(3'h0, 1'b0);
        watch(50);
        check("len", len, 0);
        wr(3'h0, 1'b0);
        watch(120);
        check_pulse(SHORT);
        check("period", psel_o, 3'h4);
        check("warn", warn_o, 1'b1);
        wr(3'h4, 1'b0);
        watch(20);
        check_pulse(SHORT);
        check("ctrl", ctrl_o, 1'b1);
        check("limp", {limp_n, limp_oe}, 2'b01);
        clr_fb();
        check("limp", {limp_n, limp_oe}, 2'b10);
        @(posedge clk) en_val <= 1'b1;
        pulse(S_EN);
        tick(2);
        check("en", en_o, 1'b1);
        pulse(S_SWR);
        watch(20);
        check_pulse(SHORT);
        check("en", en_o, 1'b0);
        clr_fb();
        // inside the open window
        tick(720);
        wr(3'h4, 1'b1);
        watch(20);
        check_pulse(SHORT);
        cm(wdr_pkg::WD_TIMEOUT);
        clr_fb();
        @(posedge clk) mcode <= 2'h0;
        cm(wdr_pkg::WD_OFF);
        @(posedge clk) irq <= 1'b1;
        cm(wdr_pkg::WD_TIMEOUT);
        wr(3'h4, 1'b1);
        tick(3);
        check("wmc", wmc_o, 1'b0);
        @(posedge clk) irq <= 1'b0;
        wr(3'h4, 1'b1);
        cm(wdr_pkg::WD_OFF);
        wr(3'h4, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk) wd_off <= !wd_off;
            watch(20);
            check_pulse(SHORT);
            clr_fb();
        end
        @(posedge clk) mcode <= 2'h1;
        pulse(S_SLP);
        watch(20);
        check("len", len, 0);
        cm(wdr_pkg::WD_OFF);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk) scheck <= bad[i];
            pulse(S_SLP);
            watch(20);
            check_pulse(SHORT);
            clr_fb();
        end
        @(posedge clk) mcode <= 2'h0;
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk) strap <= s[0];
            uv <= 1'b1;
            watch(40);
            check_pulse(s ? LONG : SHORT);
            @(posedge clk) uv <= 1'b0;
            clr_fb();
        end
        @(posedge clk) ot <= 1'b1;
        cm(wdr_pkg::WD_OFF);
        check("ctrl", ctrl_o, 1'b1);
        @(posedge clk) ot <= 1'b0;
        watch(40);
        check_pulse(LONG);
        clr_fb();
        check("ctrl", ctrl_o, 1'b0);
        @(posedge clk) pull <= 1'b1;
        @(posedge clk) pull <= 1'b0;
        watch(20);
        check("len", len, 0);
        check("warn", warn_o, 1'b1);
        report_and_stop();
    end
endmodule

bind watchdog_reset_failsafe_ctrl wdr_asserts #(.LONG_CYCLES(LONG_CYCLES)) asserts_inst
(
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CHIP_MODE_CODE_IN(CHIP_MODE_CODE_IN), .OVERTEMP_IN(OVERTEMP_IN),
    .WD_DISABLE_PIN_IN(WD_DISABLE_PIN_IN), .SOFT_RESET_BIT_IN(SOFT_RESET_BIT_IN),
    .SYS_RESET_N_PIN_IN(SYS_RESET_N_PIN_IN), .SYS_RESET_N_PIN_OE_OUT(SYS_RESET_N_PIN_OE_OUT),
    .WD_MODE_CTRL_OUT(WD_MODE_CTRL_OUT), .WD_MODE_OUT(WD_MODE_OUT), .ENABLE_OUT(ENABLE_OUT),
    .FALLBACK_WARN_OUT(FALLBACK_WARN_OUT), .FALLBACK_CTRL_OUT(FALLBACK_CTRL_OUT), .LIMP_N_OUT(LIMP_N_OUT),
    .LIMP_OE_OUT(LIMP_OE_OUT)
);
`default_nettype wire
